// *** core/fbid_pkg.sv ***
// Purpose: Shared constants for the 14-bit instruction decoder core.
// Assumes: One clock, four clock phases per instruction cycle.
// Notes: Opcode field positions and file addresses live here.
package fbid_pkg;
  // Clock and instruction cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int INSTR_CYCLE_NS = PHASES_PER_CYCLE * CLK_PERIOD_NS;
  // Field positions in the instruction word
  localparam int OP_MSB = 13;
  localparam int DEST_BIT = 7;
  localparam int FADDR_MSB = 6;
  localparam int BPOS_LSB = 7;
  localparam int TARGET_MSB = 10;
  // Class prefixes in bits 13:12
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Fixed control words
  localparam logic [13:0] W_KICK = 14'h0064;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_RET = 14'h0008;
  localparam logic [13:0] W_RETI = 14'h0009;
  localparam logic [13:0] W_NOP = 14'h0000;
  // Special file register addresses
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_A_ADDR = 7'h05;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  // Phase states, one-hot
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } fbid_phase_t;
endpackage

// *** core/fbid_core.sv ***
// Purpose: Decode and execute one 14-bit instruction per four clocks.
// Assumes: Instruction word valid on instr_i while phase Q1 is current.
// Notes: Register file is external, reached by address/strobe ports.
`timescale 1ns/1ns

// Overview of operation
// RL1: File operands always read before writing back.
// RL2: Destination bit zero to accumulator, one to file.
// RL3: Seven-bit file address from low bits.
// RL4: Three-bit field picks one register bit.
// RL5: Don't-care opcode bits never change behaviour.
// RL6: Rotates go through carry, only carry changes.
// RL7: Decrement/increment skip next when result zero.
// RL8: Register OR, XOR, AND update zero only.
// RL9: Bit clear, set, test-low skip; no flags.
// RL10: Test-high skips next when bit is set.
// RL11: Literal OR, XOR, AND update zero only.
// RL12: Literal subtract/add update carry, nibble, zero.
// RL13: Load literal; return with literal two cycles.
// RL14: Watchdog kick clears watchdog, sets status flags.
// RL15: Standby word enters sleep, updates status flags.
// RL16: Return and interrupt return, two cycles.
// RL17: Port self-modify reads pin levels.
// RL18: Timer-zero write clears assigned prescaler.
// RL19: Skips and jumps take two cycles, NOP second.
// RL20: Port clear still reads port first.
// RL21: Other register operations take one cycle.
// RL22: One instruction cycle is four clock phases.
// RL23: Prefix 10 calls or jumps, eleven-bit target.
module fbid_core #(
  parameter int PC_W = 13,
  parameter int STACK_D = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] port_pins_i,
  input wire logic prescaler_to_timer_i,
  input wire logic wake_i,
  output logic [PC_W-1:0] pc_o,
  output logic fetch_o,
  output logic [6:0] file_addr_o,
  output logic file_rd_o,
  output logic file_wr_o,
  output logic [7:0] file_wdata_o,
  output logic port_read_o,
  output logic prescaler_clear_o,
  output logic [7:0] acc_o,
  output logic carry_o,
  output logic nibble_overflow_bit_o,
  output logic zero_o,
  output logic watchdog_expiry_flag_o,
  output logic sleep_entry_flag_o,
  output logic watchdog_clear_o,
  output logic standby_o,
  output logic int_return_o
);
  // Parameter sanity, refused at elaboration; the jump keeps pc bits above 10
  if (PC_W < 12 || PC_W > 16) begin : g_pc_w_check
    $error("PC_W must be 12..16");
  end
  if (STACK_D < 1 || STACK_D > 16) begin : g_stack_d_check
    $error("STACK_D must be 1..16");
  end

  localparam int SP_W = (STACK_D > 1) ? $clog2(STACK_D) : 1;

  // Add with carry in, giving {carry, nibble carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {s[8], n[4], s[7:0]};
  endfunction

  fbid_pkg::fbid_phase_t phase_q; // Current phase inside the cycle
  logic [13:0] ir_q; // Instruction held for this cycle
  logic [7:0] rd_q; // Operand read from the file
  logic flush_q; // Next cycle runs as a NOP
  logic sleep_q; // Core halted in standby
  logic [PC_W-1:0] stack_q [STACK_D]; // Return address stack
  logic [SP_W-1:0] sp_q; // Stack pointer, wraps on overflow

  // Decoded fields
  logic [1:0] cls;
  logic [3:0] sub;
  logic dest;
  logic [2:0] bpos;
  logic [7:0] lit;
  logic uses_file;
  assign cls = ir_q[fbid_pkg::OP_MSB -: 2];
  assign sub = ir_q[11:8];
  assign dest = ir_q[fbid_pkg::DEST_BIT]; // RL2
  assign bpos = ir_q[fbid_pkg::BPOS_LSB +: 3]; // RL4
  assign lit = ir_q[7:0];

  // Only bit words and byte words other than control words and clear-acc name a file register
  function automatic logic is_file_op(input logic [13:0] w);
    logic r;
    r = 1'b0;
    if (w[13:12] == fbid_pkg::CLS_BIT) r = 1'b1;
    if (w[13:12] == fbid_pkg::CLS_BYTE) begin
      r = w[7] || (w[11:8] != 4'h0 && w[11:8] != 4'h1);
    end
    return r;
  endfunction

  assign uses_file = is_file_op(ir_q);

  // Execution results, computed during Q3
  logic [7:0] res;
  logic wr_acc, wr_file, set_c, set_dc, set_z, skip, jump, do_call;
  logic do_ret, do_reti, do_kick, do_sleep;
  logic [9:0] sum;
  logic [7:0] nv, tv;

  always_comb begin
    res = rd_q;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    set_c = 1'b0;
    set_dc = 1'b0;
    set_z = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    do_call = 1'b0;
    do_ret = 1'b0;
    do_reti = 1'b0;
    do_kick = 1'b0;
    do_sleep = 1'b0;
    sum = 10'h000;
    nv = 8'h00;
    tv = 8'h00;
    case (cls)
      fbid_pkg::CLS_BYTE: begin
        // Result goes where the destination bit says
        wr_acc = !dest; // RL2
        wr_file = dest; // RL2
        case (sub)
          4'h0: begin
            if (dest) begin
              res = acc_o; // Move accumulator to file
            end else begin
              // Control words; bits 6:5 of NOP pattern are don't-care
              wr_acc = 1'b0;
              do_kick = ir_q == fbid_pkg::W_KICK; // RL14
              do_sleep = ir_q == fbid_pkg::W_SLEEP; // RL15
              do_ret = ir_q == fbid_pkg::W_RET; // RL16
              do_reti = ir_q == fbid_pkg::W_RETI; // RL16
            end
          end
          4'h1: begin
            res = 8'h00; // Clear file or accumulator; low bits don't-care for the accumulator RL5
            set_z = 1'b1;
          end
          4'h2: begin
            sum = add8(rd_q, ~acc_o, 1'b1); // File minus accumulator
            res = sum[7:0];
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          4'h3: begin
            res = rd_q - 8'h01;
            set_z = 1'b1;
          end
          4'h4: begin
            res = rd_q | acc_o; // RL8
            set_z = 1'b1; // RL8
          end
          4'h5: begin
            res = rd_q & acc_o; // RL8
            set_z = 1'b1; // RL8
          end
          4'h6: begin
            res = rd_q ^ acc_o; // RL8
            set_z = 1'b1; // RL8
          end
          4'h7: begin
            sum = add8(rd_q, acc_o, 1'b0);
            res = sum[7:0];
            set_c = 1'b1;
            set_dc = 1'b1;
            set_z = 1'b1;
          end
          4'h8: begin
            set_z = 1'b1; // Move file to itself or accumulator
          end
          4'h9: begin
            res = ~rd_q;
            set_z = 1'b1;
          end
          4'hA: begin
            res = rd_q + 8'h01;
            set_z = 1'b1;
          end
          4'hB: begin
            res = rd_q - 8'h01; // RL7
            skip = res == 8'h00; // RL7
          end
          4'hC: begin
            res = {carry_o, rd_q[7:1]}; // RL6
            sum = {rd_q[0], 9'h000}; // Carry out in sum[9] RL6
            set_c = 1'b1; // RL6
          end
          4'hD: begin
            res = {rd_q[6:0], carry_o}; // RL6
            sum = {rd_q[7], 9'h000}; // RL6
            set_c = 1'b1; // RL6
          end
          4'hE: res = {rd_q[3:0], rd_q[7:4]};
          4'hF: begin
            res = rd_q + 8'h01; // RL7
            skip = res == 8'h00; // RL7
          end
          default: res = rd_q;
        endcase
      end
      fbid_pkg::CLS_BIT: begin
        // Bit operations never touch the status flags
        nv = rd_q;
        nv[bpos] = ir_q[10]; // RL9
        res = nv;
        wr_file = !ir_q[11]; // RL9
        tv = rd_q >> bpos; // RL4
        if (ir_q[11]) skip = tv[0] == ir_q[10]; // RL9 RL10
      end
      fbid_pkg::CLS_JUMP: begin
        jump = 1'b1; // RL23
        do_call = !ir_q[11]; // RL23
      end
      default: begin
        wr_acc = 1'b1;
        case (sub)
          4'h0, 4'h1, 4'h2, 4'h3: res = lit; // RL13
          4'h4, 4'h5, 4'h6, 4'h7: begin
            res = lit; // RL13
            do_ret = 1'b1; // RL13
          end
          4'h8: begin
            res = acc_o | lit; // RL11
            set_z = 1'b1; // RL11
          end
          4'h9: begin
            res = acc_o & lit; // RL11
            set_z = 1'b1; // RL11
          end
          4'hA: begin
            res = acc_o ^ lit; // RL11
            set_z = 1'b1; // RL11
          end
          4'hC, 4'hD: begin
            sum = add8(lit, ~acc_o, 1'b1); // RL12
            res = sum[7:0];
            set_c = 1'b1; // RL12
            set_dc = 1'b1; // RL12
            set_z = 1'b1; // RL12
          end
          4'hE, 4'hF: begin
            sum = add8(lit, acc_o, 1'b0); // RL12
            res = sum[7:0];
            set_c = 1'b1; // RL12
            set_dc = 1'b1; // RL12
            set_z = 1'b1; // RL12
          end
          default: wr_acc = 1'b0; // Unassigned literal code acts as NOP
        endcase
      end
    endcase
  end

  // Phase sequencer; halts at Q1 while in standby
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_q <= fbid_pkg::PH_Q1;
    end else begin
      case (phase_q)
        fbid_pkg::PH_Q1: if (!sleep_q) phase_q <= fbid_pkg::PH_Q2; // RL22
        fbid_pkg::PH_Q2: phase_q <= fbid_pkg::PH_Q3; // RL22
        fbid_pkg::PH_Q3: phase_q <= fbid_pkg::PH_Q4; // RL22
        fbid_pkg::PH_Q4: phase_q <= fbid_pkg::PH_Q1; // RL22
        default: phase_q <= fbid_pkg::PH_Q1;
      endcase
    end
  end

  // Q1: take the word, or a NOP when the previous one skipped or jumped
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ir_q <= fbid_pkg::W_NOP;
      file_addr_o <= 7'h00;
      file_rd_o <= 1'b0;
    end else if (phase_q == fbid_pkg::PH_Q1 && !sleep_q) begin
      ir_q <= flush_q ? fbid_pkg::W_NOP : instr_i; // RL19
      file_addr_o <= instr_i[fbid_pkg::FADDR_MSB:0]; // RL3
      file_rd_o <= !flush_q && is_file_op(instr_i); // RL1
    end else if (phase_q == fbid_pkg::PH_Q2) begin
      file_rd_o <= 1'b0;
    end
  end

  // Q2: capture operand; the port reads its pins, not its latch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_q <= 8'h00;
      port_read_o <= 1'b0;
    end else if (phase_q == fbid_pkg::PH_Q2) begin
      rd_q <= (file_addr_o == fbid_pkg::PORT_A_ADDR) ? port_pins_i : file_rdata_i; // RL17
      port_read_o <= uses_file && file_addr_o == fbid_pkg::PORT_A_ADDR; // RL20
    end else begin
      port_read_o <= 1'b0;
    end
  end

  // Q3: commit accumulator, flags and write strobe; Q4 drops strobes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_o <= fbid_pkg::ACC_RST;
      carry_o <= 1'b0;
      nibble_overflow_bit_o <= 1'b0;
      zero_o <= 1'b0;
      file_wr_o <= 1'b0;
      file_wdata_o <= 8'h00;
      prescaler_clear_o <= 1'b0;
    end else if (phase_q == fbid_pkg::PH_Q3) begin
      if (wr_acc) acc_o <= res; // RL2
      if (set_c) carry_o <= sum[9]; // RL6 RL12
      if (set_dc) nibble_overflow_bit_o <= sum[8]; // RL12
      if (set_z) zero_o <= res == 8'h00; // RL8 RL11
      file_wr_o <= wr_file && uses_file; // RL1 RL2
      file_wdata_o <= res;
      prescaler_clear_o <= wr_file && uses_file && prescaler_to_timer_i &&
                           file_addr_o == fbid_pkg::TIMER_ZERO_ADDR; // RL18
    end else if (phase_q == fbid_pkg::PH_Q4) begin
      file_wr_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
    end
  end

  // Program counter, stack and the NOP slot after a taken change
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pc_o <= PC_W'(fbid_pkg::PC_RST);
      sp_q <= '0;
      flush_q <= 1'b0;
      int_return_o <= 1'b0;
    end else if (phase_q == fbid_pkg::PH_Q3) begin
      // A plain instruction finishes in one cycle RL21
      flush_q <= skip || jump || do_ret || do_reti; // RL19
      int_return_o <= do_reti; // RL16
      if (flush_q) begin
        pc_o <= pc_o; // Second cycle of a two-cycle op RL19
      end else if (jump) begin
        pc_o <= {pc_o[PC_W-1:11], ir_q[fbid_pkg::TARGET_MSB:0]}; // RL23
        if (do_call) begin
          stack_q[sp_q] <= pc_o + 1'b1; // RL23
          sp_q <= (sp_q == SP_W'(STACK_D - 1)) ? '0 : sp_q + 1'b1;
        end
      end else if (do_ret || do_reti) begin
        pc_o <= stack_q[sp_q == '0 ? SP_W'(STACK_D - 1) : sp_q - 1'b1]; // RL13 RL16
        sp_q <= (sp_q == '0) ? SP_W'(STACK_D - 1) : sp_q - 1'b1;
      end else begin
        pc_o <= pc_o + (skip ? PC_W'(2) : PC_W'(1)); // RL7 RL10
      end
    end else begin
      int_return_o <= 1'b0;
    end
  end

  // Fetch strobe is high in the cycle in which instr_i is sampled and throughout standby
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fetch_o <= 1'b0;
    end else begin
      fetch_o <= phase_q == fbid_pkg::PH_Q4 || (phase_q == fbid_pkg::PH_Q1 && sleep_q);
    end
  end

  // Watchdog and standby status; the flags are active-low style bits
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      watchdog_expiry_flag_o <= 1'b1;
      sleep_entry_flag_o <= 1'b1;
      watchdog_clear_o <= 1'b0;
      standby_o <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      watchdog_clear_o <= phase_q == fbid_pkg::PH_Q3 && (do_kick || do_sleep); // RL14 RL15
      if (phase_q == fbid_pkg::PH_Q3 && do_kick) begin
        watchdog_expiry_flag_o <= 1'b1; // RL14
        sleep_entry_flag_o <= 1'b1; // RL14
      end
      if (phase_q == fbid_pkg::PH_Q3 && do_sleep) begin
        watchdog_expiry_flag_o <= 1'b1; // RL15
        sleep_entry_flag_o <= 1'b0; // RL15
      end
      // Wake wins over entry in the same cycle so no wake is lost
      if (wake_i) begin
        sleep_q <= 1'b0;
        standby_o <= 1'b0;
      end else if (phase_q == fbid_pkg::PH_Q4 && ir_q == fbid_pkg::W_SLEEP) begin
        sleep_q <= 1'b1; // RL15
        standby_o <= 1'b1;
      end
    end
  end
endmodule

// *** sim/fbid_core_props.sv ***
// Purpose: Port-level timing checks for the instruction decoder core.
// Assumes: One clock, sync active-high reset, four phases per cycle.
// Notes: Bound into every fbid_core instance.
`timescale 1ns/1ns
module fbid_core_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic prescaler_to_timer_i,
  input wire logic fetch_o,
  input wire logic [6:0] file_addr_o,
  input wire logic file_rd_o,
  input wire logic file_wr_o,
  input wire logic port_read_o,
  input wire logic prescaler_clear_o,
  input wire logic watchdog_expiry_flag_o,
  input wire logic watchdog_clear_o,
  input wire logic standby_o,
  input wire logic int_return_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Three quiet phases after each fetch phase
  sequence s_quiet3;
    !fetch_o [*3];
  endsequence
  // Operand read, one gap phase, then write-back
  sequence s_rd_then_wr;
    file_rd_o ##2 file_wr_o;
  endsequence
  a_write_after_read: assert property (file_wr_o |-> $past(file_rd_o, 2))
    else $error("file write without earlier read");
  a_addr_held_rmw: assert property (s_rd_then_wr |-> file_addr_o == $past(file_addr_o, 2))
    else $error("file address moved during read-modify-write");
  a_fetch_spacing: assert property ($fell(fetch_o) |-> s_quiet3)
    else $error("instruction cycle is not four phases");
  a_single_write: assert property (file_wr_o |=> !file_wr_o [*3])
    else $error("more than one write in a cycle");
  a_port_pins_read: assert property (port_read_o |-> $past(file_rd_o) && file_addr_o == 7'h05)
    else $error("port read strobe without port operand read");
  a_prescaler_cause: assert property (prescaler_clear_o |-> file_wr_o && prescaler_to_timer_i
    && file_addr_o == 7'h01)
    else $error("prescaler cleared without timer write");
  a_prescaler_due: assert property (file_wr_o && file_addr_o == 7'h01 && prescaler_to_timer_i
    |-> prescaler_clear_o)
    else $error("timer write left prescaler alone");
  a_kick_flags: assert property (watchdog_clear_o |-> watchdog_expiry_flag_o)
    else $error("watchdog clear without expiry flag set");
  a_standby_halt: assert property (standby_o |-> fetch_o)
    else $error("phases ran during standby");
  a_intret_next: assert property (int_return_o |=> fetch_o)
    else $error("interrupt return not followed by fetch");
endmodule

bind fbid_core fbid_core_props u_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .prescaler_to_timer_i(prescaler_to_timer_i),
  .fetch_o(fetch_o),
  .file_addr_o(file_addr_o),
  .file_rd_o(file_rd_o),
  .file_wr_o(file_wr_o),
  .port_read_o(port_read_o),
  .prescaler_clear_o(prescaler_clear_o),
  .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
  .watchdog_clear_o(watchdog_clear_o),
  .standby_o(standby_o),
  .int_return_o(int_return_o)
);

// *** sim/fbid_core_tb_top.sv ***
// Purpose: Self-checking bench for the instruction decoder core.
// Assumes: Bench plays program memory and file registers at the ports.
// Notes: Each step spans one instruction cycle; checks land in Q4.
`timescale 1ns/1ns
module fbid_core_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0] file_rdata_i = 8'h00;
  logic [7:0] port_pins_i = 8'h00;
  logic prescaler_to_timer_i = 1'b0;
  logic wake_i = 1'b0;
  logic [12:0] pc_o;
  logic [6:0] file_addr_o;
  logic [7:0] file_wdata_o, acc_o;
  logic fetch_o, file_rd_o, file_wr_o, port_read_o, prescaler_clear_o, carry_o;
  logic nibble_overflow_bit_o, zero_o, watchdog_expiry_flag_o, sleep_entry_flag_o;
  logic watchdog_clear_o, standby_o, int_return_o;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  // Values sampled in Q2 and Q3 of the last step
  logic rd_s, pr_s;
  logic [6:0] ad_s;
  // Side inputs applied at the next step
  logic [7:0] pins_v = 8'h00;
  logic tz_v = 1'b0;
  logic [12:0] p;
  logic [7:0] a = 8'h00; // Expected accumulator

  fbid_core dut_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .instr_i(instr_i),
    .file_rdata_i(file_rdata_i),
    .port_pins_i(port_pins_i),
    .prescaler_to_timer_i(prescaler_to_timer_i),
    .wake_i(wake_i),
    .pc_o(pc_o),
    .fetch_o(fetch_o),
    .file_addr_o(file_addr_o),
    .file_rd_o(file_rd_o),
    .file_wr_o(file_wr_o),
    .file_wdata_o(file_wdata_o),
    .port_read_o(port_read_o),
    .prescaler_clear_o(prescaler_clear_o),
    .acc_o(acc_o),
    .carry_o(carry_o),
    .nibble_overflow_bit_o(nibble_overflow_bit_o),
    .zero_o(zero_o),
    .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
    .sleep_entry_flag_o(sleep_entry_flag_o),
    .watchdog_clear_o(watchdog_clear_o),
    .standby_o(standby_o),
    .int_return_o(int_return_o)
  );

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  task conclude();
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task ck(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One instruction cycle; entered in Q4, returns in the next Q4
  task step(input logic [13:0] w, input logic [7:0] d);
    @(posedge clk_i);
    instr_i <= w;
    file_rdata_i <= d;
    port_pins_i <= pins_v;
    prescaler_to_timer_i <= tz_v;
    @(posedge clk_i);
    #1 rd_s = file_rd_o;
    ad_s = file_addr_o;
    @(posedge clk_i);
    #1 pr_s = port_read_o;
    @(posedge clk_i);
    #1;
  endtask

  // Accumulator and carry, nibble, zero flags
  task af(input logic [7:0] ea, input logic [2:0] ef);
    ck("acc", 16'(ea), 16'(acc_o));
    ck("flags", 16'(ef), 16'({carry_o, nibble_overflow_bit_o, zero_o}));
  endtask

  task lit(input logic [13:0] w, input logic [7:0] ea, input logic [2:0] ef);
    step(w, 8'h00);
    af(ea, ef);
  endtask

  // File operand: read, address, write-back and result
  task rmw(input logic [13:0] w, input logic [7:0] d, input logic we, input logic [7:0] wd,
           input logic [7:0] ea, input logic [2:0] ef);
    step(w, d);
    ck("read", 16'h0001, 16'(rd_s));
    ck("addr", 16'(w[6:0]), 16'(ad_s));
    ck("write", 16'(we), 16'(file_wr_o));
    if (we) begin
      ck("wdata", 16'(wd), 16'(file_wdata_o));
    end
    af(ea, ef);
  endtask

  // Conditional op then a literal load that a skip must discard
  task skip_case(input logic [13:0] w, input logic [7:0] d, input logic sk);
    p = pc_o;
    step(w, d);
    ck("pc", 16'(p + (sk ? 13'h0002 : 13'h0001)), 16'(pc_o));
    step(14'h3000 | 14'(d ^ 8'h5a), 8'h00);
    if (!sk) begin
      a = d ^ 8'h5a;
    end
    ck("acc", 16'(a), 16'(acc_o));
    ck("pc", 16'(p + 13'h0002), 16'(pc_o));
  endtask

  task tmr(input logic [13:0] w, input logic tz, input logic e);
    tz_v = tz;
    step(w, 8'h00);
    ck("prescaler", 16'(e), 16'(prescaler_clear_o));
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    // First cycle runs the idle word already on instr_i
    repeat (3) @(posedge clk_i);
    #1;
    lit(14'h330f, 8'h0f, 3'b000);
    lit(14'h38f0, 8'hff, 3'b000);
    lit(14'h3aff, 8'h00, 3'b001);
    lit(14'h303c, 8'h3c, 3'b001);
    lit(14'h390f, 8'h0c, 3'b000);
    lit(14'h3f04, 8'h10, 3'b010);
    lit(14'h3c10, 8'h00, 3'b111);
    lit(14'h3eff, 8'hff, 3'b000);
    lit(14'h3f01, 8'h00, 3'b111);
    lit(14'h300f, 8'h0f, 3'b111);
    rmw(14'h047f, 8'h30, 1'b0, 8'h00, 8'h3f, 3'b110);
    rmw(14'h06a2, 8'h3f, 1'b1, 8'h00, 8'h3f, 3'b111);
    rmw(14'h0510, 8'hf1, 1'b0, 8'h00, 8'h31, 3'b110);
    rmw(14'h0d91, 8'h41, 1'b1, 8'h83, 8'h31, 3'b010);
    rmw(14'h0c11, 8'h01, 1'b0, 8'h00, 8'h00, 3'b110);
    pins_v = 8'ha5;
    rmw(14'h0485, 8'h00, 1'b1, 8'ha5, 8'h00, 3'b110);
    ck("port_read", 16'h0001, 16'(pr_s));
    rmw(14'h0185, 8'h5a, 1'b1, 8'h00, 8'h00, 3'b111);
    ck("port_read", 16'h0001, 16'(pr_s));
    tmr(14'h0681, 1'b1, 1'b1);
    tmr(14'h0601, 1'b1, 1'b0);
    tmr(14'h0681, 1'b0, 1'b0);
    rmw(14'h15b0, 8'h00, 1'b1, 8'h08, 8'h00, 3'b111);
    rmw(14'h13b1, 8'hff, 1'b1, 8'h7f, 8'h00, 3'b111);
    // Remaining byte operations; the chain ends with acc 00 and flags 111
    rmw(14'h0720, 8'h0f, 1'b0, 8'h00, 8'h0f, 3'b000);
    rmw(14'h02a0, 8'h1e, 1'b1, 8'h0f, 8'h0f, 3'b100);
    rmw(14'h0920, 8'h3c, 1'b0, 8'h00, 8'hc3, 3'b100);
    rmw(14'h0e20, 8'h5a, 1'b0, 8'h00, 8'ha5, 3'b100);
    rmw(14'h00a0, 8'h00, 1'b1, 8'ha5, 8'ha5, 3'b100);
    rmw(14'h03a0, 8'h01, 1'b1, 8'h00, 8'ha5, 3'b101);
    rmw(14'h0820, 8'h80, 1'b0, 8'h00, 8'h80, 3'b100);
    lit(14'h017f, 8'h00, 3'b101);
    rmw(14'h0aa0, 8'hff, 1'b1, 8'h00, 8'h00, 3'b101);
    rmw(14'h02a0, 8'h00, 1'b1, 8'h00, 8'h00, 3'b111);
    skip_case(14'h1d40, 8'h04, 1'b1);
    skip_case(14'h1d40, 8'hfb, 1'b0);
    skip_case(14'h1940, 8'h00, 1'b1);
    skip_case(14'h1940, 8'h04, 1'b0);
    skip_case(14'h0bc0, 8'h01, 1'b1);
    skip_case(14'h0fc0, 8'hff, 1'b1);
    skip_case(14'h0fc0, 8'h10, 1'b0);
    ck("zero", 16'h0001, 16'(zero_o));
    step(14'h2923, 8'h00);
    ck("pc", 16'h0123, 16'(pc_o));
    step(14'h3055, 8'h00);
    ck("acc", 16'(a), 16'(acc_o));
    ck("pc", 16'h0123, 16'(pc_o));
    step(14'h2200, 8'h00);
    ck("pc", 16'h0200, 16'(pc_o));
    step(fbid_pkg::W_NOP, 8'h00);
    step(14'h3466, 8'h00);
    ck("acc", 16'h0066, 16'(acc_o));
    ck("pc", 16'h0124, 16'(pc_o));
    step(fbid_pkg::W_NOP, 8'h00);
    step(14'h2250, 8'h00);
    step(fbid_pkg::W_NOP, 8'h00);
    step(fbid_pkg::W_RET, 8'h00);
    ck("pc", 16'h0125, 16'(pc_o));
    af(8'h66, 3'b111);
    step(fbid_pkg::W_NOP, 8'h00);
    step(14'h2260, 8'h00);
    step(fbid_pkg::W_NOP, 8'h00);
    step(fbid_pkg::W_RETI, 8'h00);
    ck("int_return", 16'h0001, 16'(int_return_o));
    ck("pc", 16'h0126, 16'(pc_o));
    step(fbid_pkg::W_NOP, 8'h00);
    step(fbid_pkg::W_KICK, 8'h00);
    ck("wdt_clear", 16'h0001, 16'(watchdog_clear_o));
    ck("status", 16'h0003, 16'({watchdog_expiry_flag_o, sleep_entry_flag_o}));
    step(fbid_pkg::W_SLEEP, 8'h00);
    ck("wdt_clear", 16'h0001, 16'(watchdog_clear_o));
    ck("status", 16'h0002, 16'({watchdog_expiry_flag_o, sleep_entry_flag_o}));
    repeat (4) @(posedge clk_i);
    #1 ck("standby", 16'h0001, 16'(standby_o));
    @(posedge clk_i);
    wake_i <= 1'b1;
    // Bounded wait for the core to leave standby
    for (int i = 0; i < 20 && standby_o !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    ck("standby", 16'h0000, 16'(standby_o));
    // Core resumes in Q1 and reruns the standby word; wake held, so no halt
    repeat (3) @(posedge clk_i);
    #1;
    step(fbid_pkg::W_KICK, 8'h00);
    ck("status", 16'h0003, 16'({watchdog_expiry_flag_o, sleep_entry_flag_o}));
    conclude();
  end
endmodule
